// [mcp_pkg.sv]
// Package of constants and types for the modem configuration parameter block
package mcp_pkg;
  // Register byte offsets
  localparam logic [7:0] MCP_OFS_ADC_REF   = 8'h00;
  localparam logic [7:0] MCP_OFS_RATE      = 8'h04;
  localparam logic [7:0] MCP_OFS_CCA       = 8'h08;
  localparam logic [7:0] MCP_OFS_SEQ       = 8'h0C;
  localparam logic [7:0] MCP_OFS_ROLE      = 8'h10;
  localparam logic [7:0] MCP_OFS_CHAN      = 8'h14;
  localparam logic [7:0] MCP_OFS_TIMEOUT   = 8'h18;
  localparam logic [7:0] MCP_OFS_LINE_BASE = 8'h1C;
  localparam logic [7:0] MCP_OFS_CTRL      = 8'h34;
  localparam logic [7:0] MCP_OFS_STATUS    = 8'h38;
  localparam logic [7:0] MCP_OFS_FREQ      = 8'h3C;
  localparam logic [7:0] MCP_OFS_ACTRATE   = 8'h40;
  // Reset values and range limits
  localparam logic        MCP_RST_ADC_REF = 1'b0;
  localparam logic [16:0] MCP_RST_RATE    = 17'h0_0003;
  localparam logic [6:0]  MCP_RST_CCA     = 7'h2C;
  localparam logic [6:0]  MCP_MAX_CCA     = 7'h50;
  localparam logic [7:0]  MCP_RST_SEQ     = 8'h2B;
  localparam logic        MCP_RST_ROLE    = 1'b0;
  localparam logic [4:0]  MCP_RST_CHAN    = 5'h0C;
  localparam logic [4:0]  MCP_MIN_CHAN    = 5'h0C;
  localparam logic [4:0]  MCP_MAX_CHAN    = 5'h17;
  localparam logic [15:0] MCP_RST_TIMEOUT = 16'h0064;
  localparam logic [15:0] MCP_MIN_TIMEOUT = 16'h0002;
  localparam logic [2:0]  MCP_RST_LINE    = 3'h0;
  localparam logic [2:0]  MCP_RST_LINE5   = 3'h1;
  localparam logic [2:0]  MCP_MAX_LINE    = 3'h5;
  localparam logic [16:0] MCP_MAX_STD     = 17'h0_0007;
  localparam logic [16:0] MCP_MAX_RATE    = 17'h1_C200;
  // Line function codes
  localparam logic [2:0]  MCP_LF_OFF   = 3'h0;
  localparam logic [2:0]  MCP_LF_ASSOC = 3'h1;
  localparam logic [2:0]  MCP_LF_DOLO  = 3'h4;
  localparam logic [2:0]  MCP_LF_DOHI  = 3'h5;
  // Frequency: 2405 MHz + 5 MHz * (ch - 11)
  localparam int          MCP_F0_MHZ    = 2405;
  localparam int          MCP_FSTEP_MHZ = 5;
  localparam int          MCP_CH_BASE   = 11;
  // Timing
  localparam int          MCP_CLK_HZ    = 200_000_000;
  localparam int          MCP_TICK_MS   = 100;
  localparam int          MCP_BLINK_MS  = 250;
  localparam logic [31:0] MCP_RATE_TBL [8] = '{32'd1200, 32'd2400, 32'd4800, 32'd9600,
                                               32'd19200, 32'd38400, 32'd57600, 32'd115200};
  // Command mode states
  typedef enum logic [2:0] {
    MCP_DATA  = 3'b001,
    MCP_GUARD = 3'b010,
    MCP_CMD   = 3'b100
  } mcp_mode_e;
  // Host byte carrier
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mcp_byte_s;
endpackage

// [mcp_config_params.sv]
// Modem configuration parameter set with command mode tracking and line control
// Summary of operation
// R01: ADC reference: 0 pin, 1 internal
// R02: Rate codes 0-7 map standard bps
// R03: New rate applies after exit and OK
// R04: Above 7 is literal baud, closest stored
// R05: Rate read returns stored value
// R06: Host uses flow control when faster
// R07: Drop transmission when energy above threshold
// R08: Threshold 0 to 0x50, default 0x2C
// R09: Guard, sequence char, guard enters command
// R10: Command bytes not forwarded as payload
// R11: Role 0 end device, 1 coordinator
// R12: Channel 0x0C-0x17, default 0x0C
// R13: Same channel needed to exchange data
// R14: Frequency 2405 plus 5 per channel step
// R15: Exit command leaves command mode immediately
// R16: Idle timeout in 100 ms units
// R17: Timeout reads as two bytes
// R18: Five lines select ADC/DI/DO, default 0
// R19: Fifth line codes, default associate
// R20: Fifth line blinks while associated
// R21: Sixth line selects RTS, ADC, DI, DO
// R22: Host byte restarts idle counter
//
// Design decisions made here: the APB register port and the register offsets.
module mcp_config_params
  import mcp_pkg::*;
#(
  parameter int CLK_HZ    = MCP_CLK_HZ,
  parameter int GUARD_CYC = 200_000,
  parameter int TICK_CYC  = MCP_CLK_HZ / 1000 * MCP_TICK_MS,
  parameter int BLINK_CYC = MCP_CLK_HZ / 1000 * MCP_BLINK_MS
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Host byte stream from serial receiver
  input  wire mcp_pkg::mcp_byte_s host_rx,
  output mcp_pkg::mcp_byte_s      payload_out,
  // Exit command decoded and OK sent
  input  wire logic              exit_cmd,
  input  wire logic              ok_sent,
  // Clear channel assessment
  input  wire logic              tx_request,
  input  wire logic [6:0]        energy_level,
  output logic                   tx_go,
  output logic                   tx_drop,
  // Radio state and status
  input  wire logic              associated,
  output logic                   cmd_mode,
  output logic [31:0]            active_rate_bps,
  output logic                   coordinator,
  output logic                   adc_ref_internal,
  output logic [4:0]             radio_channel,
  output logic [11:0]            center_freq_mhz,
  // Line five and six pins
  output logic                   gp_line_five_o,
  output logic                   gp_line_five_oe,
  output logic                   gp_line_six_o,
  output logic                   gp_line_six_oe
);
  import mcp_pkg::*;

  localparam int NLINES = 7;          // Lines 0..6

  // Configuration storage
  logic             adc_ref_select_r;           // Reference select
  logic [16:0]      host_rate_code_r;           // Stored rate parameter
  logic [6:0]       clear_channel_threshold_r;  // Threshold in -dBm
  logic [7:0]       sequence_char_r;            // Escape character
  logic             role_r;                     // Coordinator flag
  logic [4:0]       radio_channel_r;            // Channel number
  logic [15:0]      cmd_idle_timeout_r;         // Timeout in ticks
  logic [2:0]       line_function_r [NLINES];   // Line function codes
  logic             exit_pend_r;                // Waiting for OK after exit
  logic [31:0]      rate_nxt;                   // Rounded rate code
  logic             wr_en;                      // APB write strobe
  logic             rd_en;                      // APB read strobe

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // Rate rounding: nearest divisor of clock/16 gives achievable baud
  function automatic logic [16:0] mcp_round_rate(input logic [31:0] req);
    logic [31:0] div;
    logic [31:0] got;
    div = 32'((CLK_HZ / 16 + req / 2) / req);
    if (div == 32'h0000_0000) begin
      div = 32'h0000_0001;
    end
    got = 32'(CLK_HZ / 16) / div;
    if (got > 32'(MCP_MAX_RATE)) begin
      got = 32'(MCP_MAX_RATE);
    end
    return got[16:0];
  endfunction

  // Rate code decode for a write
  always_comb begin
    if (pwdata <= 32'(MCP_MAX_STD)) begin
      rate_nxt = pwdata;                                   // [R02]
    end else if (pwdata <= 32'(MCP_MAX_RATE)) begin
      rate_nxt = 32'(mcp_round_rate(pwdata));              // [R04]
    end else begin
      rate_nxt = 32'(host_rate_code_r);
    end
  end

  // Parameter writes; out-of-range threshold, channel, timeout and rate writes are ignored
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      adc_ref_select_r          <= MCP_RST_ADC_REF;         // [R01]
      host_rate_code_r          <= MCP_RST_RATE;            // [R02]
      clear_channel_threshold_r <= MCP_RST_CCA;             // [R08]
      sequence_char_r           <= MCP_RST_SEQ;             // [R09]
      role_r                    <= MCP_RST_ROLE;            // [R11]
      radio_channel_r           <= MCP_RST_CHAN;            // [R12]
      cmd_idle_timeout_r        <= MCP_RST_TIMEOUT;         // [R16]
    end else if (wr_en) begin
      case (paddr)
        MCP_OFS_ADC_REF: adc_ref_select_r <= pwdata[0];    // [R01]
        MCP_OFS_RATE: host_rate_code_r <= rate_nxt[16:0];  // [R04]
        MCP_OFS_CCA: begin
          if (pwdata <= 32'(MCP_MAX_CCA)) begin
            clear_channel_threshold_r <= pwdata[6:0];      // [R08]
          end
        end
        MCP_OFS_SEQ: sequence_char_r <= pwdata[7:0];       // [R09]
        MCP_OFS_ROLE: role_r <= pwdata[0];                 // [R11]
        MCP_OFS_CHAN: begin
          if (pwdata >= 32'(MCP_MIN_CHAN) && pwdata <= 32'(MCP_MAX_CHAN)) begin
            radio_channel_r <= pwdata[4:0];                // [R12]
          end
        end
        MCP_OFS_TIMEOUT: begin
          if (pwdata >= 32'(MCP_MIN_TIMEOUT) && pwdata[31:16] == 16'h0000) begin
            cmd_idle_timeout_r <= pwdata[15:0];            // [R16]
          end
        end
        default: ;
      endcase
    end
  end

  // Per-line function registers
  genvar gi;
  generate
    for (gi = 0; gi < NLINES; gi++) begin : g_line
      localparam logic [7:0] OFS = 8'(MCP_OFS_LINE_BASE + 8'(4 * gi));
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          line_function_r[gi] <= (gi == 5) ? MCP_RST_LINE5 : MCP_RST_LINE; // [R18] [R19]
        end else if (wr_en && paddr == OFS && pwdata <= 32'(MCP_MAX_LINE)) begin
          line_function_r[gi] <= pwdata[2:0];              // [R18] [R21]
        end
      end
    end
  endgenerate

  // Host byte synchroniser is not needed: receiver runs on sys_clk
  // Command mode tracker
  mcp_mode_e        mode_r;          // Escape state
  logic [31:0]      guard_cnt_r;     // Silence counter
  logic [31:0]      tick_cnt_r;      // 100 ms prescaler
  logic [15:0]      idle_cnt_r;      // Idle ticks in command mode
  logic             tick;            // One 100 ms tick

  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

  // Silence counter restarts on each host byte
  always_ff @(posedge sys_clk) begin
    if (srst || host_rx.valid) begin
      guard_cnt_r <= 32'h0000_0000;
    end else if (guard_cnt_r < 32'(GUARD_CYC)) begin
      guard_cnt_r <= guard_cnt_r + 32'h0000_0001;
    end
  end

  // Mode sequence: guard, char, guard; exit or timeout leaves
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_r <= MCP_DATA;
    end else begin
      case (mode_r)
        MCP_DATA: begin
          if (host_rx.valid && host_rx.data == sequence_char_r &&
              guard_cnt_r >= 32'(GUARD_CYC)) begin
            mode_r <= MCP_GUARD;                           // [R09]
          end
        end
        MCP_GUARD: begin
          if (host_rx.valid) begin
            mode_r <= MCP_DATA;   // Char not followed by silence
          end else if (guard_cnt_r >= 32'(GUARD_CYC)) begin
            mode_r <= MCP_CMD;                             // [R09]
          end
        end
        MCP_CMD: begin
          if (exit_cmd) begin
            mode_r <= MCP_DATA;                            // [R15]
          end else if (tick && idle_cnt_r + 16'h0001 >= cmd_idle_timeout_r) begin
            mode_r <= MCP_DATA;                            // [R16]
          end
        end
        default: mode_r <= MCP_DATA;
      endcase
    end
  end

  // 100 ms prescaler, restarted with the idle count
  always_ff @(posedge sys_clk) begin
    if (srst || mode_r != MCP_CMD || host_rx.valid || tick) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // Idle tick counter
  always_ff @(posedge sys_clk) begin
    if (srst || mode_r != MCP_CMD || host_rx.valid) begin
      idle_cnt_r <= 16'h0000;                              // [R22]
    end else if (tick) begin
      idle_cnt_r <= idle_cnt_r + 16'h0001;                 // [R16]
    end
  end

  // Payload forwarding, blocked in command mode; escape char passes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      payload_out <= '0;
    end else begin
      payload_out.valid <= host_rx.valid && mode_r == MCP_DATA; // [R10]
      payload_out.data  <= host_rx.data;
    end
  end

  // Active rate switches only after exit and OK
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      exit_pend_r     <= 1'b0;
      active_rate_bps <= MCP_RATE_TBL[MCP_RST_RATE[2:0]];
    end else begin
      if (exit_cmd && mode_r == MCP_CMD) begin
        exit_pend_r <= 1'b1;
      end else if (ok_sent) begin
        exit_pend_r <= 1'b0;
      end
      if (exit_pend_r && ok_sent) begin
        active_rate_bps <= (host_rate_code_r <= MCP_MAX_STD) ?
                           MCP_RATE_TBL[host_rate_code_r[2:0]] :
                           32'(host_rate_code_r);          // [R03]
      end
    end
  end

  // Clear channel assessment: drop when energy above threshold
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_go   <= 1'b0;
      tx_drop <= 1'b0;
    end else begin
      tx_go   <= tx_request && energy_level <= clear_channel_threshold_r; // [R07]
      tx_drop <= tx_request && energy_level >  clear_channel_threshold_r; // [R07]
    end
  end

  // Channel and derived frequency; peers match on this channel
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      radio_channel   <= MCP_RST_CHAN;
      center_freq_mhz <= 12'(MCP_F0_MHZ + MCP_FSTEP_MHZ * (32'(MCP_RST_CHAN) - MCP_CH_BASE));
    end else begin
      radio_channel   <= radio_channel_r;                  // [R13]
      center_freq_mhz <= 12'(MCP_F0_MHZ +
                         MCP_FSTEP_MHZ * (32'(radio_channel_r) - MCP_CH_BASE)); // [R14]
    end
  end

  // Role, reference and mode status outputs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      coordinator      <= 1'b0;
      adc_ref_internal <= 1'b0;
      cmd_mode         <= 1'b0;
    end else begin
      coordinator      <= role_r;                          // [R11]
      adc_ref_internal <= adc_ref_select_r;                // [R01]
      cmd_mode         <= (mode_r == MCP_CMD);             // [R10]
    end
  end

  // Association blink timer
  logic [31:0] blink_cnt_r;   // Half-period counter
  logic        blink_r;       // Blink phase
  always_ff @(posedge sys_clk) begin
    if (srst || !associated) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= 1'b0;
    end else if (blink_cnt_r == 32'(BLINK_CYC - 1)) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= ~blink_r;                             // [R20]
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end

  // Line five and six drivers; flow control and inputs leave pin undriven
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gp_line_five_o  <= 1'b0;
      gp_line_five_oe <= 1'b0;
      gp_line_six_o   <= 1'b0;
      gp_line_six_oe  <= 1'b0;
    end else begin
      case (line_function_r[5])
        MCP_LF_ASSOC: begin
          gp_line_five_oe <= 1'b1;
          gp_line_five_o  <= associated & blink_r;         // [R20]
        end
        MCP_LF_DOLO: begin
          gp_line_five_oe <= 1'b1;
          gp_line_five_o  <= 1'b0;                         // [R19]
        end
        MCP_LF_DOHI: begin
          gp_line_five_oe <= 1'b1;
          gp_line_five_o  <= 1'b1;                         // [R19]
        end
        default: begin
          gp_line_five_oe <= 1'b0;
          gp_line_five_o  <= 1'b0;
        end
      endcase
      gp_line_six_oe <= (line_function_r[6] == MCP_LF_DOLO) ||
                        (line_function_r[6] == MCP_LF_DOHI); // [R21]
      gp_line_six_o  <= (line_function_r[6] == MCP_LF_DOHI);
    end
  end

  // APB read mux and answer; no wait state, unmapped reads zero with error
  logic [31:0] rd_data;   // Combinational read value
  logic        rd_hit;    // Address decoded
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr)
      MCP_OFS_ADC_REF: rd_data = 32'(adc_ref_select_r);
      MCP_OFS_RATE:    rd_data = 32'(host_rate_code_r);                  // [R05]
      MCP_OFS_CCA:     rd_data = 32'(clear_channel_threshold_r);
      MCP_OFS_SEQ:     rd_data = 32'(sequence_char_r);
      MCP_OFS_ROLE:    rd_data = 32'(role_r);
      MCP_OFS_CHAN:    rd_data = 32'(radio_channel_r);
      MCP_OFS_TIMEOUT: rd_data = 32'(cmd_idle_timeout_r);                // [R17]
      MCP_OFS_STATUS:  rd_data = {29'h0000_0000, exit_pend_r, associated,
                                  mode_r == MCP_CMD};
      MCP_OFS_FREQ:    rd_data = 32'(center_freq_mhz);
      MCP_OFS_ACTRATE: rd_data = active_rate_bps;
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < NLINES; i++) begin
          if (paddr == 8'(MCP_OFS_LINE_BASE + 8'(4 * i))) begin
            rd_data = 32'(line_function_r[i]);
            rd_hit  = 1'b1;
          end
        end
      end
    endcase
  end

  // Answer registered: pready rises in the first access cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= rd_data;
      pslverr <= psel & ~penable & ~rd_hit;
    end
  end
endmodule

// [mcp_config_params_chk.sv]
// Port timing checker for the configuration parameter block
module mcp_config_params_chk
  import mcp_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               srst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire mcp_pkg::mcp_byte_s host_rx,
  input wire mcp_pkg::mcp_byte_s payload_out,
  input wire logic               exit_cmd,
  input wire logic               ok_sent,
  input wire logic               tx_request,
  input wire logic               tx_go,
  input wire logic               tx_drop,
  input wire logic               cmd_mode,
  input wire logic [31:0]        active_rate_bps,
  input wire logic [4:0]         radio_channel,
  input wire logic [11:0]        center_freq_mhz
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Answer comes in the first access cycle
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  // Every request gets exactly one verdict
  tx_one_a: assert property (tx_request |=> tx_go ^ tx_drop)
    else $error("no single verdict for tx request");
  // No verdict without a request
  tx_quiet_a: assert property (!tx_request |=> !tx_go && !tx_drop)
    else $error("verdict without request");
  // Payload only from data mode bytes, unchanged
  fwd_cause_a: assert property (payload_out.valid |-> $past(host_rx.valid)
    && !$past(cmd_mode) && payload_out.data == $past(host_rx.data))
    else $error("payload not caused by data mode byte");
  // Entry only after a quiet line
  entry_quiet_a: assert property ($rose(cmd_mode) |-> !$past(host_rx.valid, 2))
    else $error("command mode entered right after a byte");
  // Exit command acts at once
  exit_now_a: assert property (cmd_mode && exit_cmd |=> ##1 !cmd_mode)
    else $error("exit command ignored");
  // Frequency follows channel
  freq_map_a: assert property ($stable(radio_channel) [*2] |->
    center_freq_mhz == 12'(MCP_F0_MHZ + MCP_FSTEP_MHZ * (int'(radio_channel) - MCP_CH_BASE)))
    else $error("center frequency wrong");
  // Channel stays in its range
  chan_range_a: assert property (radio_channel >= 5'h0C && radio_channel <= 5'h17)
    else $error("channel out of range");
  // Host rate moves only on the OK edge
  rate_hold_a: assert property (!ok_sent |=> $stable(active_rate_bps))
    else $error("host rate changed without OK");
  cover property ($rose(cmd_mode));
  cover property (tx_drop);
  cover property (ok_sent ##1 $changed(active_rate_bps));
endmodule

bind mcp_config_params mcp_config_params_chk u_mcp_config_params_chk (
  .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pready(pready),
  .host_rx(host_rx), .payload_out(payload_out), .exit_cmd(exit_cmd), .ok_sent(ok_sent),
  .tx_request(tx_request), .tx_go(tx_go), .tx_drop(tx_drop), .cmd_mode(cmd_mode),
  .active_rate_bps(active_rate_bps), .radio_channel(radio_channel),
  .center_freq_mhz(center_freq_mhz));

// [mcp_host_model.sv]
// Host model: sends one byte after a silent gap, as a paced serial host would
module mcp_host_model
  import mcp_pkg::*;
#(
  parameter int GAP = 20
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       host_send,
  input  wire logic [7:0] tx_b,
  output mcp_pkg::mcp_byte_s host_rx,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap_r; // Silent cycles left before the byte
  // Guard silence, then a one-cycle byte; one byte at a time paces the host
  always_ff @(posedge sys_clk) begin
    host_rx.valid <= 1'b0;
    host_rx.data  <= ~host_rx.data; // Idle data toggles, never a stale byte
    if (srst) begin
      busy         <= 1'b0;
      gap_r        <= 0;
      host_rx.data <= 8'h5A;
    end else if (host_send && !busy) begin
      busy  <= 1'b1;
      gap_r <= GAP;
    end else if (busy && gap_r != 0) begin
      gap_r <= gap_r - 1;
    end else if (busy) begin
      host_rx.valid <= 1'b1;
      host_rx.data  <= tx_b;
      busy          <= 1'b0;
    end
  end
endmodule

// [tb_mcp_config_params.sv]
// Self-checking bench for the configuration parameter block
module tb_mcp_config_params;
  timeunit 1ns;
  timeprecision 1ps;
  import mcp_pkg::*;
  localparam int GC  = 20;               // Shortened guard interval
  localparam int C16 = MCP_CLK_HZ / 16;  // Rate divisor base
  logic        sys_clk, srst, psel, penable, pwrite, exit_cmd, ok_sent, host_send;
  logic        tx_request, associated, pready, pslverr, tx_go, tx_drop, cmd_mode;
  logic        coordinator, adc_ref_internal, l5_o, l5_oe, busy, l6_o, l6_oe;
  logic [7:0]  paddr, tx_b, last_pay;
  logic [31:0] pwdata, prdata, active_rate_bps, q;
  logic [6:0]  energy_level;
  logic [4:0]  radio_channel;
  logic [11:0] center_freq_mhz;
  mcp_byte_s   host_rx, payload_out;
  int m[13] = '{0, 3, 'h2C, 'h2B, 0, 'h0C, 'h64, 0, 0, 0, 0, 0, 1}; // Model registers
  int lim[13] = '{2, 'h1D000, 'h60, 'h100, 2, 'h1C, 'h11000, 8, 8, 8, 8, 8, 8};
  int bi[8] = '{5, 5, 5, 5, 2, 2, 6, 6};               // Boundary register
  int bv[8] = '{'h17, 'h18, 'h0B, 'h0C, 'h51, 'h50, 1, 2}; // Boundary value
  int n_mismatch, total_checks, seed, cyc, n_pay, i, k, v;

  mcp_config_params #(.GUARD_CYC(GC), .TICK_CYC(10), .BLINK_CYC(4)) u_mcp_config_params (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_rx(host_rx), .payload_out(payload_out), .exit_cmd(exit_cmd), .ok_sent(ok_sent),
    .tx_request(tx_request), .energy_level(energy_level), .tx_go(tx_go), .tx_drop(tx_drop),
    .associated(associated), .cmd_mode(cmd_mode), .active_rate_bps(active_rate_bps),
    .coordinator(coordinator), .adc_ref_internal(adc_ref_internal),
    .radio_channel(radio_channel), .center_freq_mhz(center_freq_mhz),
    .gp_line_five_o(l5_o), .gp_line_five_oe(l5_oe), .gp_line_six_o(l6_o), .gp_line_six_oe(l6_oe));
  mcp_host_model #(.GAP(GC)) u_mcp_host_model (.sys_clk(sys_clk), .srst(srst),
    .host_send(host_send), .tx_b(tx_b), .host_rx(host_rx), .busy(busy));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Payload monitor and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (payload_out.valid === 1'b1) begin
      n_pay++;
      last_pay = payload_out.data;
    end
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Closest rate the divider can make
  function automatic int near(int r);
    int d;
    d = C16 / r;
    if (C16 / d - r > r - C16 / (d + 1)) d++;
    return C16 / d;
  endfunction
  // One APB transfer; holds the request until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge sys_clk);
      n++;
    end
    q = prdata;
    chk(pready, 1);
    chk(pslverr, a > 8'h40);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Model write: refused values keep the old setting
  task automatic wr(input int i, input int v);
    bit ok;
    case (i)
      0, 4: ok = v <= 1;
      1: ok = v <= 'h1C200;
      2: ok = v <= 'h50;
      3: ok = v <= 'hFF;
      5: ok = v >= 'h0C && v <= 'h17;
      6: ok = v >= 2 && v <= 'hFFFF;
      default: ok = v <= 5;
    endcase
    if (ok) m[i] = (i == 1 && v > 7) ? near(v) : v;
    apb(1'b1, 8'(i * 4), 32'(v));
  endtask
  // Read back; stored rate may differ by one from rounding
  task automatic rd(input int i);
    apb(1'b0, 8'(i * 4), 32'h0);
    if (i == 1 && m[1] > 7 && (q - m[1] + 1) <= 2) q = m[1];
    chk(q, m[i]);
  endtask
  task automatic outs();
    repeat (2) @(posedge sys_clk);
    chk(adc_ref_internal, m[0]);
    chk(coordinator, m[4]);
    chk(radio_channel, m[5]);
    chk(center_freq_mhz, 2405 + 5 * (m[5] - 11));
  endtask
  task automatic put_byte(input logic [7:0] b);
    @(posedge sys_clk);
    host_send <= 1'b1;
    tx_b      <= b;
    @(posedge sys_clk);
    host_send <= 1'b0;
    repeat (GC + 3) @(posedge sys_clk);
  endtask

  initial begin
    seed = 75;
    {psel, penable, pwrite, exit_cmd, ok_sent, tx_request, associated, host_send} = '0;
    {paddr, tx_b, pwdata, energy_level} = '0;
    srst = 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    // Reset values and the unmapped word
    for (i = 0; i < 13; i++) begin
      rd(i);
    end
    outs();
    chk(active_rate_bps, 9600);
    apb(1'b0, 8'h44, 32'h0);
    chk(q, 0);
    // Random and boundary writes, each read back
    for (i = 0; i < 128; i++) begin
      k = (i < 8) ? bi[i] : $unsigned($random(seed)) % 13;
      v = (i < 8) ? bv[i] : $unsigned($random(seed)) % lim[k];
      if (k == 1 && v > 7 && v < 'h80) v = v % 8;
      wr(k, v);
      rd(k);
      outs();
    end
    // Clear channel verdicts around the threshold
    wr(2, 'h2C);
    for (i = 0; i < 24; i++) begin
      v = (i < 3) ? 'h2B + i : $unsigned($random(seed)) % 128;
      @(posedge sys_clk);
      tx_request   <= 1'b1;
      energy_level <= 7'(v);
      @(posedge sys_clk);
      tx_request <= 1'b0;
      @(posedge sys_clk);
      chk({tx_go, tx_drop}, (v > 'h2C) ? 1 : 2);
    end
    // Data byte forwarded, then guarded entry and idle timeout
    wr(3, 'h7E);
    wr(6, 5);
    put_byte(8'h41);
    repeat (GC) @(posedge sys_clk);
    chk(last_pay, 8'h41);
    chk(cmd_mode, 0);
    put_byte(8'h7E);
    repeat (GC + 4) @(posedge sys_clk);
    chk(cmd_mode, 1);
    v = n_pay;
    put_byte(8'h42);
    put_byte(8'h43);
    repeat (30) @(posedge sys_clk);
    chk(cmd_mode, 1);
    chk(n_pay, v);
    repeat (40) @(posedge sys_clk);
    chk(cmd_mode, 0);
    // New host rate waits for exit and OK
    wr(1, 5);
    put_byte(8'h7E);
    repeat (GC + 4) @(posedge sys_clk);
    exit_cmd <= 1'b1;
    @(posedge sys_clk);
    exit_cmd <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk(cmd_mode, 0);
    chk(active_rate_bps, 9600);
    ok_sent <= 1'b1;
    @(posedge sys_clk);
    ok_sent <= 1'b0;
    @(posedge sys_clk);
    chk(active_rate_bps, MCP_RATE_TBL[5]);
    // Fifth line: blink while associated, then driven levels and off; sixth line driven high
    associated <= 1'b1;
    wr(12, 1);
    v = 0;
    for (i = 0; i < 24; i++) begin
      @(posedge sys_clk);
      v += (l5_o === 1'b1);
    end
    chk(v > 0 && v < 24 && l5_oe === 1'b1, 1);
    for (k = 4; k < 6; k++) begin
      wr(12, k);
      repeat (3) @(posedge sys_clk);
      chk({l5_oe, l5_o}, k - 2);
    end
    wr(12, 0);
    repeat (3) @(posedge sys_clk);
    chk(l5_oe, 0);
    apb(1'b1, 8'h34, 32'h5);
    repeat (3) @(posedge sys_clk);
    chk({l6_oe, l6_o}, 3);
    end_of_test();
  end
endmodule
